// ### src/agp_pkg.sv
/*
  Constants shared by the converter post-processing gain path.
  Assumes one sampling clock and two's complement converter words.
*/
package agp_pkg;

  // ==========================================================
  // Data format
  localparam int DATA_W = 14;
  localparam int GAIN_W = 4;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 14;
  localparam int FS_W = 12;

  // ==========================================================
  // Gain codes: one step is half a decibel
  localparam logic [3:0] GAIN_CODE_0DB = 4'h0;
  localparam logic [3:0] GAIN_CODE_MAX = 4'hc;

  // ==========================================================
  // Latency, in sampling-clock cycles
  localparam int LAT_BYPASS = 10;
  localparam int FIFO_LAT = 1;
  localparam int DELAY_STAGES = LAT_BYPASS - FIFO_LAT;
  localparam int GAIN_STAGES = 3;
  localparam int LAT_PROCESSED = LAT_BYPASS + GAIN_STAGES;

  // ==========================================================
  // Output buffer
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;

  // ==========================================================
  // Reset values
  localparam logic RST_BYPASS_DISABLED = 1'b0;
  localparam logic [3:0] RST_GAIN_CODE = 4'h0;

  // Path selection
  typedef enum logic {
    AGP_PATH_BYPASS,
    AGP_PATH_PROCESSED
  } agp_path_e;

endpackage

// ### src/agp_fifo.sv
/*
  Synchronous FIFO with registered read data and valid/ready on both sides.
  Assumes a single clock; the fill count is exported for credit checks.
*/
`timescale 1ns/1ps

module agp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Occupancy, memory plus output register
  output logic [AW:0] count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] mem_count;
  logic push;
  logic pop_mem;

  // Memory side moves into the output register when it is free
  assign in_ready = (mem_count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop_mem = (mem_count != '0) && (!out_valid || out_ready);
  assign count = mem_count + {{AW{1'b0}}, out_valid};

  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_mem) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      mem_count <= mem_count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
    end
  end

  // Registered read data; holds while the drain side stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else if (pop_mem) begin
      out_data <= mem[rd_ptr];
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // agp_fifo

// ### src/agp_gain_path.sv
/*
  Post-processing path between the converter core and the output pins:
  a fixed-latency bypass, a half-decibel gain stage with saturation,
  and an output FIFO with back-pressure toward the converter.
  Assumes all inputs are synchronous to ref_clk and that converter
  words are two's complement.
*/
// Behaviour
// (R1) In bypass the raw word leaves unchanged ten cycles after it is taken.
// (R2) With the digital functions in the path the word takes extra cycles.
// (R3) Reset selects the bypass, so no digital function is active.
// (R4) The host sets the bypass-disable bit before programming any function.
// (R5) Gain is chosen from 0 dB to 6 dB in half-decibel steps.
// (R6) The full-scale range shrinks with gain, 2 V at 0 dB to 1 V at 6 dB.
// (R7) Gain is off after reset, starts at 0 dB on leaving bypass, then follows writes.
// (R8) Gain multiplies each word and saturates instead of wrapping.
`timescale 1ns/1ps

module agp_gain_path (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Converter words
  input wire logic [agp_pkg::DATA_W-1:0] adc_data,
  input wire logic adc_valid,
  output logic adc_ready,
  // Configuration
  input wire logic bypass_path_disable,
  input wire logic [agp_pkg::GAIN_W-1:0] gain_code,
  input wire logic gain_write,
  // Status
  output logic gain_active,
  output logic [agp_pkg::GAIN_W-1:0] gain_setting,
  output logic [agp_pkg::FS_W-1:0] full_scale_mv,
  // Output words toward the receiver
  output logic [agp_pkg::DATA_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  // Local shorthands for package widths and depths
  localparam int DW = agp_pkg::DATA_W;
  localparam int NS = agp_pkg::DELAY_STAGES;
  localparam int PW = DW + agp_pkg::COEF_W + 1;
  localparam int INFLIGHT = agp_pkg::DELAY_STAGES + agp_pkg::GAIN_STAGES;
  // Credit threshold: the delay line and gain stage can hold INFLIGHT
  // words that the count does not see yet, plus the one being taken
  localparam logic [agp_pkg::FIFO_AW:0] CREDIT_LIMIT =
    (agp_pkg::FIFO_AW + 1)'(agp_pkg::FIFO_DEPTH - INFLIGHT - 1);
  localparam logic signed [DW-1:0] CODE_MAX = {1'b0, {(DW-1){1'b1}}};
  localparam logic signed [DW-1:0] CODE_MIN = {1'b1, {(DW-1){1'b0}}};

  // ==========================================================
  // Lookup functions

  // Gain factor, unsigned with COEF_FRAC fraction bits
  function automatic logic [agp_pkg::COEF_W-1:0] gain_coef(
    input logic [agp_pkg::GAIN_W-1:0] code
  );
    unique case (code)
      4'h0: gain_coef = 16'h4000;
      4'h1: gain_coef = 16'h43cb;
      4'h2: gain_coef = 16'h47cf;
      4'h3: gain_coef = 16'h4c10;
      4'h4: gain_coef = 16'h5092;
      4'h5: gain_coef = 16'h5558;
      4'h6: gain_coef = 16'h5a67;
      4'h7: gain_coef = 16'h5fc2;
      4'h8: gain_coef = 16'h656f;
      4'h9: gain_coef = 16'h6b71;
      4'ha: gain_coef = 16'h71cf;
      4'hb: gain_coef = 16'h788e;
      4'hc: gain_coef = 16'h7fb2;
      default: gain_coef = 16'h4000;
    endcase
  endfunction

  // Input full-scale range in millivolts peak-to-peak
  function automatic logic [agp_pkg::FS_W-1:0] full_scale(
    input logic [agp_pkg::GAIN_W-1:0] code
  );
    unique case (code)
      4'h0: full_scale = 12'h7d0;
      4'h1: full_scale = 12'h760;
      4'h2: full_scale = 12'h6f4;
      4'h3: full_scale = 12'h693;
      4'h4: full_scale = 12'h636;
      4'h5: full_scale = 12'h5dc;
      4'h6: full_scale = 12'h58c;
      4'h7: full_scale = 12'h539;
      4'h8: full_scale = 12'h4ec;
      4'h9: full_scale = 12'h4a7;
      4'ha: full_scale = 12'h460;
      4'hb: full_scale = 12'h426;
      4'hc: full_scale = 12'h3e8;
      default: full_scale = 12'h7d0;
    endcase
  endfunction

  // Path decode, shared by the status, the gain feed and the output select
  function automatic logic is_processed(
    input agp_pkg::agp_path_e p
  );
    is_processed = (p == agp_pkg::AGP_PATH_PROCESSED);
  endfunction

  // Clip a widened result to the end codes; at 6 dB a full-scale input
  // would otherwise wrap to the opposite sign
  function automatic logic [DW-1:0] clip_word(
    input logic signed [PW-1:0] v
  );
    if (v > PW'(CODE_MAX)) begin
      clip_word = CODE_MAX; // R8
    end else if (v < PW'(CODE_MIN)) begin
      clip_word = CODE_MIN; // R8
    end else begin
      clip_word = v[DW-1:0];
    end
  endfunction

  // ==========================================================
  // Configuration state

  agp_pkg::agp_path_e path;
  logic bypass_disable_q;
  logic [agp_pkg::GAIN_W-1:0] gain_q;
  logic enter_processed;
  logic [agp_pkg::GAIN_W-1:0] gain_clamped;

  // Rising edge of the bypass-disable bit against last cycle's copy
  assign enter_processed = bypass_path_disable && !bypass_disable_q;
  // Codes above the 6 dB step clamp to it rather than wrap
  assign gain_clamped = (gain_code > agp_pkg::GAIN_CODE_MAX) ?
                        agp_pkg::GAIN_CODE_MAX : gain_code;

  // Path follows the bypass-disable bit; bypass after reset. Words in the
  // gain stage at a return to bypass are lost, so the host switches while idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bypass_disable_q <= agp_pkg::RST_BYPASS_DISABLED; // R3
      path <= agp_pkg::AGP_PATH_BYPASS; // R3
    end else begin
      bypass_disable_q <= bypass_path_disable;
      path <= bypass_path_disable ? agp_pkg::AGP_PATH_PROCESSED :
              agp_pkg::AGP_PATH_BYPASS;
    end
  end

  // Gain register: 0 dB on leaving bypass, writes ignored while bypassed.
  // A write reaches the next word into the multiplier; words already
  // past it keep the old factor
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gain_q <= agp_pkg::RST_GAIN_CODE; // R7
    end else if (enter_processed) begin
      gain_q <= agp_pkg::GAIN_CODE_0DB; // R7
    end else if (gain_write && bypass_disable_q) begin
      gain_q <= gain_clamped; // R4 R5 R7
    end
  end

  // Status outputs, all from flip-flops; gain_active trails the bypass
  // bit by two edges, one to select the path and one to register it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gain_active <= 1'b0;
      gain_setting <= agp_pkg::RST_GAIN_CODE;
      full_scale_mv <= full_scale(agp_pkg::RST_GAIN_CODE);
    end else begin
      gain_active <= is_processed(path);
      gain_setting <= gain_q;
      full_scale_mv <= full_scale(gain_q); // R6
    end
  end

  // ==========================================================
  // Fixed delay line shared by both paths

  logic [DW-1:0] dly_data [NS];
  logic dly_valid [NS];
  logic take;

  // Words are taken only under credit, so the buffer never refuses one
  assign take = adc_valid && adc_ready;

  // One register per cycle of raw latency; nine stages plus the buffer
  // write make up the ten cycles of the bypass
  generate
    for (genvar s = 0; s < NS; s++) begin : g_dly
      if (s == 0) begin : g_first
        // First stage takes the word and its acceptance
        always_ff @(posedge ref_clk or negedge resetn) begin
          if (!resetn) begin
            dly_data[s] <= '0;
            dly_valid[s] <= 1'b0;
          end else begin
            dly_data[s] <= adc_data; // R1
            dly_valid[s] <= take;
          end
        end
      end else begin : g_next
        // Later stages only copy their neighbour
        always_ff @(posedge ref_clk or negedge resetn) begin
          if (!resetn) begin
            dly_data[s] <= '0;
            dly_valid[s] <= 1'b0;
          end else begin
            dly_data[s] <= dly_data[s-1]; // R1
            dly_valid[s] <= dly_valid[s-1];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Gain stage: multiply, round, saturate

  // Three register stages, each with its own valid
  logic signed [PW-1:0] prod;
  logic prod_valid;
  logic signed [PW-1:0] scaled;
  logic scaled_valid;
  logic [DW-1:0] gain_data;
  logic gain_valid;
  logic gain_in_valid;

  assign gain_in_valid = dly_valid[NS-1] && is_processed(path);

  // Product of the word and the factor; a zero above the factor keeps it
  // positive in the signed multiply
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prod <= '0;
      prod_valid <= 1'b0;
    end else begin
      prod <= PW'($signed(dly_data[NS-1]) * $signed({1'b0, gain_coef(gain_q)})); // R8
      prod_valid <= gain_in_valid; // R2
    end
  end

  // Round to nearest and drop the fraction bits; ties round upward
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scaled <= '0;
      scaled_valid <= 1'b0;
    end else begin
      scaled <= (prod + PW'(1 << (agp_pkg::COEF_FRAC - 1))) >>> agp_pkg::COEF_FRAC;
      scaled_valid <= prod_valid; // R2
    end
  end

  // Clip to the end codes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gain_data <= '0;
      gain_valid <= 1'b0;
    end else begin
      gain_data <= clip_word(scaled); // R8
      gain_valid <= scaled_valid; // R2
    end
  end

  // ==========================================================
  // Output selection and buffer

  // Word handed to the buffer, from either path
  logic [DW-1:0] fifo_in_data;
  logic fifo_in_valid;
  logic [agp_pkg::FIFO_AW:0] fifo_count;

  // Bypass skips the gain stage entirely; processed words gain three cycles.
  // Words still inside the gain stage when bypass returns are dropped here
  always_comb begin
    if (!is_processed(path)) begin
      fifo_in_data = dly_data[NS-1]; // R1
      fifo_in_valid = dly_valid[NS-1]; // R1
    end else begin
      fifo_in_data = gain_data; // R2
      fifo_in_valid = gain_valid; // R2
    end
  end

  // Credit check: every word in flight must find a slot, so the
  // converter is stalled well before the buffer fills.
  // Trade-off: slots stay empty while the receiver stalls, in return
  // for never dropping a word
  assign adc_ready = (fifo_count <= CREDIT_LIMIT);

  agp_fifo #(
    .WIDTH(DW),
    .DEPTH(agp_pkg::FIFO_DEPTH),
    .AW(agp_pkg::FIFO_AW)
  ) agp_fifo_i (
    .clk(ref_clk),
    .rst_n(resetn),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .count(fifo_count)
  );

endmodule // agp_gain_path

// ### sim/agp_checker.sv
/*
  Port assertions for the gain path.
  Assumes a bind from the bench top, one clock and an active-low reset.
*/
`timescale 1ns/1ps

module agp_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration
  input wire logic bypass_path_disable,
  input wire logic [agp_pkg::GAIN_W-1:0] gain_code,
  input wire logic gain_write,
  // Status
  input wire logic gain_active,
  input wire logic [agp_pkg::GAIN_W-1:0] gain_setting,
  input wire logic [agp_pkg::FS_W-1:0] full_scale_mv,
  // Output stream
  input wire logic [agp_pkg::DATA_W-1:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready
);
  // ==========================================================
  // Shared clock and reset for every property
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Bypass bit low then high: entry into the processed path
  sequence s_enable; !bypass_path_disable ##1 bypass_path_disable; endsequence
  // Write with the bypass bit already high the cycle before
  sequence s_write; bypass_path_disable ##1 (gain_write && bypass_path_disable); endsequence
  // Write while bypassed for two cycles, which must leave no trace
  sequence s_idle_write; !bypass_path_disable ##1 (gain_write && !bypass_path_disable); endsequence

  // ==========================================================
  // Path and gain register
  property p_path_on; bypass_path_disable |=> ##1 gain_active; endproperty
  a_path_on: assert property (p_path_on) else $error("gain off on path");
  property p_path_off; !bypass_path_disable |=> ##1 !gain_active; endproperty
  a_path_off: assert property (p_path_off) else $error("gain on in bypass");
  property p_enable;
    s_enable |=> ##1 (gain_setting == 4'h0 && full_scale_mv == 12'h7d0);
  endproperty
  a_enable: assert property (p_enable) else $error("no 0 dB on enable");
  property p_range; gain_setting <= agp_pkg::GAIN_CODE_MAX; endproperty
  a_range: assert property (p_range) else $error("gain out of range");
  property p_write;
    s_write |=> ##1
      (gain_setting == ($past(gain_code, 2) > 4'hc ? 4'hc : $past(gain_code, 2)));
  endproperty
  a_write: assert property (p_write) else $error("gain write lost");
  property p_ignored; s_idle_write |=> ##1 $stable(gain_setting); endproperty
  a_ignored: assert property (p_ignored) else $error("write taken in bypass");
  // Both ends of the full-scale range
  property p_fs_top; gain_setting == 4'h0 |-> full_scale_mv == 12'h7d0; endproperty
  a_fs_top: assert property (p_fs_top) else $error("full scale at 0 dB");
  property p_fs_low; gain_setting == 4'hc |-> full_scale_mv == 12'h3e8; endproperty
  a_fs_low: assert property (p_fs_low) else $error("full scale at 6 dB");
  // A stalled word stands unchanged
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled word moved");
endmodule // agp_checker

// ### sim/agp_receiver.sv
/*
  Receiver model at the gain path output.
  Assumes the bench drives stall and reads the capture queue q.
*/
`timescale 1ns/1ps

module agp_receiver (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Stream from the gain path
  input wire logic [agp_pkg::DATA_W-1:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  // Bench control
  input wire logic stall
);
  logic [agp_pkg::DATA_W-1:0] q [$];

  // ==========================================================
  // Ready moves off the sampling edge so no race with capture
  initial begin
    out_ready = 1'b0;
    forever @(negedge ref_clk) out_ready <= !stall;
  end

  // Every accepted word is kept for the bench to compare
  always @(posedge ref_clk) if (resetn && out_valid && out_ready) q.push_back(out_data);
endmodule // agp_receiver

// ### sim/agp_gain_path_bench.sv
/*
  Bench for the gain path: bypass, gain setup, processed words, fill and drain.
  Assumes agp_receiver at the output; the checker is bound below.
*/
`timescale 1ns/1ps

module agp_gain_path_bench;
  logic ref_clk, resetn, adc_valid, adc_ready, bypass_path_disable, gain_write;
  logic gain_active, out_valid, out_ready, stall;
  logic [agp_pkg::DATA_W-1:0] adc_data, out_data;
  logic [agp_pkg::GAIN_W-1:0] gain_code, gain_setting;
  logic [agp_pkg::FS_W-1:0] full_scale_mv;
  logic [11:0] fs_tab [13] = '{12'h7d0, 12'h760, 12'h6f4, 12'h693, 12'h636, 12'h5dc,
                               12'h58c, 12'h539, 12'h4ec, 12'h4a7, 12'h460, 12'h426, 12'h3e8};
  int n_fail = 0;
  int num_checks = 0;

  agp_gain_path agp_gain_path_i (.ref_clk, .resetn, .adc_data, .adc_valid, .adc_ready,
    .bypass_path_disable, .gain_code, .gain_write, .gain_active, .gain_setting,
    .full_scale_mv, .out_data, .out_valid, .out_ready);
  agp_receiver agp_receiver_i (.ref_clk, .resetn, .out_data, .out_valid, .out_ready, .stall);

  // ==========================================================
  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One-cycle gain write pulse
  task automatic pulse(logic [3:0] c);
    @(negedge ref_clk);
    gain_write = 1'b1;
    gain_code = c;
    @(negedge ref_clk);
    gain_write = 1'b0;
  endtask

  // One word through an empty path: edges to out_valid, then value
  task automatic xfer(logic [13:0] w, logic [13:0] exp, int l);
    int n = 0;
    @(negedge ref_clk);
    adc_valid = 1'b1;
    adc_data = w;
    @(negedge ref_clk);
    adc_valid = 1'b0;
    while (out_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    cyc(2);
    chk("latency", 16'(n), 16'(l));
    chk("word", 16'(agp_receiver_i.q.pop_front()), 16'(exp));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk("gain_active", 16'(gain_active), 16'h0);
    chk("gain_setting", 16'(gain_setting), 16'h0);
    chk("full_scale", 16'(full_scale_mv), 16'h7d0);
  endtask

  task automatic t_bypass;
    xfer(14'h1fff, 14'h1fff, 10);
    xfer(14'h2000, 14'h2000, 10);
    xfer(14'h0abc, 14'h0abc, 10);
  endtask

  // Write refused in bypass, gain active on enable, then every code
  task automatic t_config;
    pulse(4'h6);
    cyc(1);
    chk("refused", 16'(gain_setting), 16'h0);
    bypass_path_disable = 1'b1;
    cyc(2);
    chk("active", 16'(gain_active), 16'h1);
    for (int g = 0; g < 14; g++) begin
      pulse(g > 12 ? 4'hf : 4'(g));
      cyc(1);
      chk("setting", 16'(gain_setting), g > 12 ? 16'hc : 16'(g));
      chk("full_scale", 16'(full_scale_mv), 16'(fs_tab[g > 12 ? 12 : g]));
    end
  endtask

  // 6 dB scaling, saturation both ways, then back to 0 dB
  task automatic t_gain;
    cyc(4);
    xfer(14'h03e8, 14'h07cb, 13);
    xfer(14'h1f40, 14'h1fff, 13);
    xfer(14'h20c0, 14'h2000, 13);
    pulse(4'h0);
    cyc(2);
    xfer(14'h04d2, 14'h04d2, 13);
  endtask

  // Fill against a stalled receiver until refused, then drain in order
  task automatic t_fill;
    int n = 0;
    bypass_path_disable = 1'b0;
    stall = 1'b1;
    cyc(4);
    chk("bypass", 16'(gain_active), 16'h0);
    while (n < 60 && adc_ready === 1'b1) begin
      adc_valid = 1'b1;
      adc_data = 14'h100 + 14'(n);
      n++;
      @(negedge ref_clk);
    end
    adc_valid = 1'b0;
    chk("refused", 16'(n < 60), 16'h1);
    cyc(20);
    chk("held", 16'(out_data), 16'h100);
    stall = 1'b0;
    cyc(90);
    chk("count", 16'(agp_receiver_i.q.size()), 16'(n));
    for (int i = 0; i < n; i++) chk("order", 16'(agp_receiver_i.q.pop_front()), 16'h100 + 16'(i));
  endtask

  // Re-entry from bypass restarts at 0 dB whatever gain was left behind
  task automatic t_reentry;
    bypass_path_disable = 1'b1;
    cyc(2);
    pulse(4'h5);
    cyc(1);
    chk("set", 16'(gain_setting), 16'h5);
    bypass_path_disable = 1'b0;
    cyc(2);
    bypass_path_disable = 1'b1;
    cyc(2);
    chk("reentry", 16'(gain_setting), 16'h0);
    chk("reentry_fs", 16'(full_scale_mv), 16'h7d0);
  endtask

  // Reset in mid-run with a gain set: back to bypass at 0 dB, words flow
  task automatic t_rereset;
    pulse(4'h9);
    cyc(1);
    chk("before", 16'(gain_setting), 16'h9);
    resetn = 1'b0;
    cyc(2);
    bypass_path_disable = 1'b0;
    resetn = 1'b1;
    t_reset;
    cyc(2);
    chk("bypass", 16'(gain_active), 16'h0);
    xfer(14'h1234, 14'h1234, 10);
  endtask

  // ==========================================================
  // Main sequence; a hang is cut short by the watchdog
  initial begin
    resetn = 1'b0;
    adc_valid = 1'b0;
    adc_data = '0;
    bypass_path_disable = 1'b0;
    gain_write = 1'b0;
    gain_code = '0;
    stall = 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    t_reset;
    t_bypass;
    t_config;
    t_gain;
    t_fill;
    t_reentry;
    t_rereset;
    close_out;
  end

  initial begin
    #60us;
    n_fail++;
    close_out;
  end
endmodule // agp_gain_path_bench

bind agp_gain_path agp_checker agp_checker_i (.ref_clk, .resetn, .bypass_path_disable,
  .gain_code, .gain_write, .gain_active, .gain_setting, .full_scale_mv, .out_data,
  .out_valid, .out_ready);
